//--- hw/chs_params.svh
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CHS_OFF_CTRL 12'h000
`define CHS_OFF_T1 12'h004
`define CHS_OFF_T2 12'h008
`define CHS_OFF_STAT 12'h00C
`define CHS_OFF_ELAP 12'h010

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CHS_CTRL_RUN_BIT 0
`define CHS_CTRL_RST 32'h0000_0001
`define CHS_T1_RST 32'h0000_1000
`define CHS_T2_RST 32'h0000_2000

// ----------------------------------------------------------------
// Charge current command codes (fraction of the constant current)
// ----------------------------------------------------------------
`define CHS_CUR_OFF 2'h0
`define CHS_CUR_PRE 2'h1
`define CHS_CUR_CC 2'h2
`define CHS_CUR_CV 2'h3

// ----------------------------------------------------------------
// Timing: the first timer spans 1/8 (prequal), 1 (CV), 1/2 (top-off)
// ----------------------------------------------------------------
`define CHS_PRE_SHIFT 3
`define CHS_TOP_SHIFT 1

`endif

//--- hw/chs_pkg.sv
package chs_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CHS_RESET = 3'b000,
    CHS_PREQUAL = 3'b001,
    CHS_CC = 3'b010,
    CHS_CV = 3'b011,
    CHS_TOPOFF = 3'b100,
    CHS_DONE = 3'b101,
    CHS_FAULT = 3'b110
  } chs_state_t;

endpackage : chs_pkg

//--- hw/chs_tmr_if.sv
`timescale 1ns/100ps

// Timer control between sequencer and phase timer
interface chs_tmr_if #(parameter int W = 32);
  logic clear;
  logic run;
  logic [W-1:0] limit;
  logic expired;
  logic [W-1:0] count;
  modport seq (output clear, output run, output limit, input expired, input count);
  modport tmr (input clear, input run, input limit, output expired, output count);
endinterface : chs_tmr_if

//--- hw/chs_timer.sv
`timescale 1ns/100ps

module chs_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  chs_tmr_if.tmr t
);

  typedef struct packed {
    logic [W-1:0] count;
    logic expired;
  } chs_tmr_state_t;

  chs_tmr_state_t r;
  chs_tmr_state_t next_r;

  initial begin
    if (W < 4 || W > 32) $error("chs_timer: W out of range");
  end

  // Count while running, hold while paused, clear on request
  always_comb begin
    next_r = r;
    if (t.clear) begin
      next_r.count = '0;
      next_r.expired = 1'b0;
    end else if (t.run && !r.expired) begin
      if (r.count + 1'b1 >= t.limit) begin
        next_r.expired = 1'b1;
      end
      next_r.count = W'(r.count + 1'b1);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign t.expired = r.expired;
  assign t.count = r.count;

endmodule : chs_timer

//--- hw/chs_sequencer.sv
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "chs_params.svh"

module chs_sequencer #(
  parameter int TW = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator results from the analog front end
  input wire logic batt_above_uv,
  input wire logic batt_at_reg,
  input wire logic chg_below_10pct,
  input wire logic batt_below_rechg,
  input wire logic batt_over_ov,
  input wire logic low_headroom,
  input wire logic temp_ok,
  // Charger command and indicators
  output logic [1:0] chg_cmd,
  output logic cc_phase_flag_n,
  output logic cv_phase_flag_n,
  output logic abnormal_end_n
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (TW < 8 || TW > 32) $error("chs_sequencer: TW out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers (pins from the analog side)
  // ----------------------------------------------------------------
  localparam int NI = 7;
  logic [NI-1:0] pin_raw;
  logic [NI-1:0] sync1;
  logic [NI-1:0] sync2;
  assign pin_raw = {batt_above_uv, batt_at_reg, chg_below_10pct, batt_below_rechg,
                    batt_over_ov, low_headroom, temp_ok};

  // Two-flop synchroniser per input bit
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic s_uv_ok;
  logic s_reg;
  logic s_low_i;
  logic s_rechg;
  logic s_ov;
  logic s_headroom;
  logic s_temp;
  assign {s_uv_ok, s_reg, s_low_i, s_rechg, s_ov, s_headroom, s_temp} = sync2;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    chs_pkg::chs_state_t state;
    logic run_request;
    logic [TW-1:0] t1_limit;
    logic [TW-1:0] t2_limit;
    logic [1:0] chg_cmd;
    logic cc_n;
    logic cv_n;
    logic fault_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } chs_seq_state_t;

  chs_seq_state_t r;
  chs_seq_state_t next_r;

  // ----------------------------------------------------------------
  // Phase timers
  // ----------------------------------------------------------------
  chs_tmr_if #(.W(TW)) t1 ();
  chs_tmr_if #(.W(TW)) t2 ();

  chs_timer #(.W(TW)) u_short_phase_timer (
    .pclk(pclk),
    .presetn(presetn),
    .t(t1.tmr)
  );

  chs_timer #(.W(TW)) u_cc_phase_timer (
    .pclk(pclk),
    .presetn(presetn),
    .t(t2.tmr)
  );

  logic state_change;
  logic restart;
  assign restart = r.run_request || s_headroom || s_ov;
  assign state_change = (next_r.state != r.state);

  // Timer control: both cleared in reset, the first also at every phase change, paused when hot/cold
  always_comb begin
    t1.clear = (r.state == chs_pkg::CHS_RESET) || state_change;
    t2.clear = (r.state == chs_pkg::CHS_RESET);
    t1.run = s_temp && (r.state == chs_pkg::CHS_PREQUAL || r.state == chs_pkg::CHS_CV
             || r.state == chs_pkg::CHS_TOPOFF);
    t2.run = s_temp && (r.state == chs_pkg::CHS_CC);
    t2.limit = r.t2_limit;
    // Phase span derived from the first setting
    unique case (r.state)
      chs_pkg::CHS_PREQUAL: t1.limit = r.t1_limit >> `CHS_PRE_SHIFT;
      chs_pkg::CHS_TOPOFF: t1.limit = r.t1_limit >> `CHS_TOP_SHIFT;
      default: t1.limit = r.t1_limit;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer, outputs and APB slave
  // ----------------------------------------------------------------
  logic apb_wr;
  logic apb_rd;
  // Write lands at the edge where pready is seen high
  assign apb_wr = psel && penable && pwrite && r.pready;
  assign apb_rd = psel && !penable;

  always_comb begin
    next_r = r;
    // Phase transitions
    if (restart) begin
      next_r.state = chs_pkg::CHS_RESET;
    end else begin
      unique case (r.state)
        chs_pkg::CHS_RESET: next_r.state = chs_pkg::CHS_PREQUAL;
        chs_pkg::CHS_PREQUAL: begin
          if (s_uv_ok && s_temp) begin
            next_r.state = chs_pkg::CHS_CC;
          end else if (t1.expired) begin
            next_r.state = chs_pkg::CHS_FAULT;
          end
        end
        chs_pkg::CHS_CC: begin
          if (s_reg && s_temp) begin
            next_r.state = chs_pkg::CHS_CV;
          end else if (t2.expired) begin
            next_r.state = chs_pkg::CHS_FAULT;
          end
        end
        chs_pkg::CHS_CV: begin
          if ((s_low_i && s_temp) || t1.expired) begin
            next_r.state = chs_pkg::CHS_TOPOFF;
          end
        end
        chs_pkg::CHS_TOPOFF: begin
          if (t1.expired) begin
            next_r.state = chs_pkg::CHS_DONE;
          end
        end
        chs_pkg::CHS_DONE: begin
          if (s_rechg) begin
            next_r.state = chs_pkg::CHS_RESET;
          end
        end
        chs_pkg::CHS_FAULT: next_r.state = chs_pkg::CHS_FAULT;
        default: next_r.state = chs_pkg::CHS_RESET;
      endcase
    end

    // Outputs follow the next state so they line up with it
    next_r.chg_cmd = `CHS_CUR_OFF;
    next_r.cc_n = 1'b1;
    next_r.cv_n = 1'b1;
    next_r.fault_n = 1'b1;
    unique case (next_r.state)
      chs_pkg::CHS_PREQUAL: begin
        next_r.chg_cmd = s_temp ? `CHS_CUR_PRE : `CHS_CUR_OFF;
        next_r.cc_n = 1'b0;
      end
      chs_pkg::CHS_CC: begin
        next_r.chg_cmd = s_temp ? `CHS_CUR_CC : `CHS_CUR_OFF;
        next_r.cc_n = 1'b0;
      end
      chs_pkg::CHS_CV: begin
        next_r.chg_cmd = s_temp ? `CHS_CUR_CV : `CHS_CUR_OFF;
        next_r.cv_n = 1'b0;
      end
      chs_pkg::CHS_TOPOFF: begin
        next_r.chg_cmd = s_temp ? `CHS_CUR_CV : `CHS_CUR_OFF;
      end
      chs_pkg::CHS_FAULT: begin
        next_r.fault_n = 1'b0;
      end
      default: begin
        next_r.chg_cmd = `CHS_CUR_OFF;
      end
    endcase

    // APB: access phase with one wait state, pready held one cycle
    next_r.pready = psel && penable && !r.pready;
    next_r.pslverr = 1'b0;
    if (apb_wr) begin
      unique case (paddr)
        `CHS_OFF_CTRL: next_r.run_request = pwdata[`CHS_CTRL_RUN_BIT];
        `CHS_OFF_T1: next_r.t1_limit = pwdata[TW-1:0];
        `CHS_OFF_T2: next_r.t2_limit = pwdata[TW-1:0];
        default: next_r.run_request = r.run_request; // Read-only or unmapped: ignored
      endcase
    end
    if (apb_rd) begin
      unique case (paddr)
        `CHS_OFF_CTRL: next_r.prdata = {31'h0000_0000, r.run_request};
        `CHS_OFF_T1: next_r.prdata = 32'(r.t1_limit);
        `CHS_OFF_T2: next_r.prdata = 32'(r.t2_limit);
        `CHS_OFF_STAT: next_r.prdata = {20'h0_0000, 1'b0, sync2, s_temp,
                                         r.state};
        `CHS_OFF_ELAP: next_r.prdata = 32'((r.state == chs_pkg::CHS_CC) ? t2.count : t1.count);
        default: next_r.prdata = 32'h0000_0000;
      endcase
      next_r.pslverr = 1'b0;
    end
    // Error flag decided one edge ahead so it stands with pready
    if (psel && penable && !r.pready) begin
      unique case (paddr)
        `CHS_OFF_CTRL, `CHS_OFF_T1, `CHS_OFF_T2, `CHS_OFF_STAT, `CHS_OFF_ELAP:
          next_r.pslverr = 1'b0;
        default: next_r.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state <= chs_pkg::CHS_RESET;
      r.run_request <= 1'(`CHS_CTRL_RST);
      r.t1_limit <= TW'(`CHS_T1_RST);
      r.t2_limit <= TW'(`CHS_T2_RST);
      r.chg_cmd <= `CHS_CUR_OFF;
      r.cc_n <= 1'b1;
      r.cv_n <= 1'b1;
      r.fault_n <= 1'b1;
      r.prdata <= 32'h0000_0000;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Ports straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign chg_cmd = r.chg_cmd;
  assign cc_phase_flag_n = r.cc_n;
  assign cv_phase_flag_n = r.cv_n;
  assign abnormal_end_n = r.fault_n;

endmodule : chs_sequencer

//--- verif/chs_seq_assertions.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Port checker for the charge sequencer
// ----------------------------------------------------------------
module chs_seq_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Comparator inputs
  input wire logic temp_ok,
  input wire logic batt_over_ov,
  // Command and indicators
  input wire logic [1:0] chg_cmd,
  input wire logic cc_phase_flag_n,
  input wire logic cv_phase_flag_n,
  input wire logic abnormal_end_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Fault shows zero current and only the abnormal flag low
  chk_fault_out: assert property (!abnormal_end_n |-> chg_cmd == 2'h0 &&
    cc_phase_flag_n && cv_phase_flag_n) else $error("fault outputs wrong");
  // Constant voltage flag excludes the current phases
  chk_cv_excl: assert property (!cv_phase_flag_n |-> cc_phase_flag_n &&
    chg_cmd != 2'h1 && chg_cmd != 2'h2) else $error("cv flag with cc state");
  // Constant current flag goes with a current command
  chk_cc_cmd: assert property (!cc_phase_flag_n && chg_cmd != 2'h0 |->
    chg_cmd inside {2'h1, 2'h2}) else $error("cc flag with wrong command");
  // Battery temperature out of range stops charging
  chk_temp_pause: assert property (!temp_ok [*5] |-> chg_cmd == 2'h0)
    else $error("charging while temperature bad");
  // Overvoltage holds the reset state
  chk_ov_reset: assert property (batt_over_ov [*5] |-> chg_cmd == 2'h0 &&
    abnormal_end_n && cc_phase_flag_n) else $error("overvoltage not reset");
  // Slave answers two edges after setup
  chk_ready_time: assert property (psel && !penable |-> ##2 pready)
    else $error("pready late");
  // Ready is a single pulse
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  // Error only with ready
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // Main scenarios reached
  cov_fault: cover property ($fell(abnormal_end_n));
  cov_cv: cover property ($fell(cv_phase_flag_n));
  cov_err: cover property (pslverr);
endmodule : chs_seq_assertions

bind chs_sequencer chs_seq_assertions chs_seq_assertions_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .temp_ok(temp_ok), .batt_over_ov(batt_over_ov),
  .chg_cmd(chg_cmd), .cc_phase_flag_n(cc_phase_flag_n),
  .cv_phase_flag_n(cv_phase_flag_n), .abnormal_end_n(abnormal_end_n));

//--- verif/chs_batt_model.sv
`timescale 1ns/100ps

// Battery and comparator model driven by the charge command
module chs_batt_model (
  // Clock and command
  input wire logic pclk,
  input wire logic [1:0] chg_cmd,
  // Test knobs: hold stalls charging, drain loads the cell
  input wire logic hold,
  input wire logic drain,
  // Comparator results
  output logic batt_above_uv,
  output logic batt_at_reg,
  output logic chg_below_10pct,
  output logic batt_below_rechg
);
  int v = 0;
  int icnt = 0;

  // Cell rises under current, falls under load; current tapers in CV
  always @(posedge pclk) begin
    if ((chg_cmd == 2'h1 || chg_cmd == 2'h2) && !hold && v < 60) v <= v + 1;
    else if (drain && v > 0) v <= v - 1;
    icnt <= (chg_cmd == 2'h3) ? icnt + 1 : 0;
  end

  // Clean digital levels toward the sequencer
  assign batt_above_uv = v > 20;
  assign batt_at_reg = v >= 60;
  assign chg_below_10pct = icnt > 40;
  assign batt_below_rechg = v < 40;
endmodule : chs_batt_model

//--- verif/chs_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "chs_params.svh"

module chs_sequencer_tb_top;
  logic pclk, presetn, psel, penable, pwrite, temp_ok, batt_over_ov, low_headroom;
  logic hold, drain, pready, pslverr, err, uv, at_reg, low_i, rechg, cc_n, cv_n, ab_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, e1;
  logic [1:0] chg_cmd;
  int miscompares = 0;
  int tests_run = 0;
  int n;

  // ----------------------------------------------------------------
  // Design, battery model and clock
  // ----------------------------------------------------------------
  chs_sequencer chs_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .batt_above_uv(uv),
    .batt_at_reg(at_reg), .chg_below_10pct(low_i), .batt_below_rechg(rechg),
    .batt_over_ov(batt_over_ov), .low_headroom(low_headroom), .temp_ok(temp_ok),
    .chg_cmd(chg_cmd), .cc_phase_flag_n(cc_n), .cv_phase_flag_n(cv_n),
    .abnormal_end_n(ab_n));
  chs_batt_model chs_batt_model_inst (.pclk(pclk), .chg_cmd(chg_cmd), .hold(hold),
    .drain(drain), .batt_above_uv(uv), .batt_at_reg(at_reg),
    .chg_below_10pct(low_i), .batt_below_rechg(rechg));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rd

  // Read the state field
  task rs(input logic [2:0] e);
    apb(1'b0, `CHS_OFF_STAT, 32'h0000_0000);
    chk(q[2:0], e);
  endtask : rs

  // Wait on the command (f=0) or the cv flag (f=1), n counts cycles
  task wt(input logic f, input logic [1:0] c);
    n = 0;
    while ((f ? {1'b0, cv_n} : chg_cmd) !== c && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 2000, 1'b1);
  endtask : wt

  task results;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, batt_over_ov, low_headroom, drain} = 7'h00;
    {temp_ok, hold} = 2'h3;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    chk({chg_cmd, cc_n, cv_n, ab_n}, 32'h0000_0007);
    presetn <= 1'b1;
    rd(`CHS_OFF_CTRL, `CHS_CTRL_RST);
    rd(`CHS_OFF_T1, `CHS_T1_RST);
    rd(`CHS_OFF_T2, `CHS_T2_RST);
    rd(12'h020, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, `CHS_OFF_T1, 32'h0000_0100);
    apb(1'b1, `CHS_OFF_T2, 32'h0000_0200);
    rd(`CHS_OFF_T1, 32'h0000_0100);
    $display("test registers done");
    // Dead cell: prequal times out after T1/8
    apb(1'b1, `CHS_OFF_CTRL, 32'h0000_0000);
    wt(1'b0, 2'h1);
    chk(cc_n, 1'b0);
    wt(1'b0, 2'h0);
    chk(n >= 30 && n <= 36, 1'b1);
    chk(ab_n, 1'b0);
    rs(3'h6);
    // Restart request returns to reset with cleared timers
    apb(1'b1, `CHS_OFF_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    chk({chg_cmd, cc_n, cv_n, ab_n}, 32'h0000_0007);
    rs(3'h0);
    rd(`CHS_OFF_ELAP, 32'h0000_0000);
    $display("test prequal fault done");
    // Full cycle with temperature pauses in CC and CV
    hold <= 1'b0;
    apb(1'b1, `CHS_OFF_CTRL, 32'h0000_0000);
    wt(1'b0, 2'h2);
    chk(cc_n, 1'b0);
    temp_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(chg_cmd, 2'h0);
    apb(1'b0, `CHS_OFF_ELAP, 32'h0000_0000);
    e1 = q;
    repeat (8) @(posedge pclk);
    rd(`CHS_OFF_ELAP, e1);
    temp_ok <= 1'b1;
    wt(1'b0, 2'h3);
    chk({cc_n, cv_n}, 2'h2);
    temp_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(chg_cmd, 2'h0);
    chk({cc_n, cv_n}, 2'h2);
    temp_ok <= 1'b1;
    wt(1'b1, 2'h1);
    chk(chg_cmd, 2'h3);
    wt(1'b0, 2'h0);
    chk(n >= 127 && n <= 134, 1'b1);
    rs(3'h5);
    drain <= 1'b1;
    wt(1'b0, 2'h1);
    drain <= 1'b0;
    hold <= 1'b1;
    $display("test full cycle done");
    // Stalled cell: CC times out after T2
    wt(1'b0, 2'h2);
    wt(1'b0, 2'h0);
    chk(n >= 510 && n <= 516, 1'b1);
    chk(ab_n, 1'b0);
    rs(3'h6);
    $display("test cc fault done");
    // Overvoltage, then low headroom, force reset
    for (int k = 0; k < 2; k++) begin
      if (k == 0) batt_over_ov <= 1'b1;
      else low_headroom <= 1'b1;
      repeat (6) @(posedge pclk);
      rs(3'h0);
      chk({cc_n, cv_n, ab_n}, 3'h7);
      {batt_over_ov, low_headroom} <= 2'h0;
      wt(1'b0, 2'h2);
    end
    $display("test restart causes done");
    results;
  end
endmodule : chs_sequencer_tb_top
